// ===== src/pgpio_top.sv
// Purpose: gpio logic for pins 16 to 31 and 32 to 45 (enable, direction, data for each)
// Assumes: pin inputs synchronous to clk_i; wishbone master holds requests until ack
// Notes:   register index is word index; byte address is four times it
// How it works
// - 16-bit data register at 0x4405, bits 15-0 map pins 31-16.
// - input-direction data bits read back the present pin level.
// - output-direction data bits drive the pin low or high as written.
// - data bits reset to the level on their pin.
// - enable register at 0x4406, bits 13-0 for pins 45-32, reset 0.
// - enable 0 floats the pin; enable 1 gives it gpio function.
// - direction register at 0x4407, bits 13-0, reset 0, 1 means output.
// - data register at 0x4408, bits 13-0 for pins 45-32.
// - third-bank bit n selects pin 32 plus n, pins 32 to 45 only.
// - direction bits for pins 16-31 at 0x4404, reset 0.
// - enable bits for pins 16-31 at 0x4403, reset 0, float when clear.
`timescale 1ns/1ps
`include "pgpio_defs.svh"
module pgpio_top
	import pgpio_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [15:0] gpio_b1_i,
	output logic      [15:0] gpio_b1_o,
	output logic      [15:0] gpio_b1_oe_o,
	input  wire logic [13:0] gpio_b2_i,
	output logic      [13:0] gpio_b2_o,
	output logic      [13:0] gpio_b2_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// register state

	pgpio_word_t pin_enable_bank1_reg;
	pgpio_word_t pin_direction_bank1_reg;
	pgpio_word_t pin_data_bank1_reg;
	pgpio_word_t pin_enable_bank2_reg;
	pgpio_word_t pin_direction_bank2_reg;
	pgpio_word_t pin_data_bank2_reg;

	pgpio_word_t pin_enable_bank1_next;
	pgpio_word_t pin_direction_bank1_next;
	pgpio_word_t pin_data_bank1_next;
	pgpio_word_t pin_enable_bank2_next;
	pgpio_word_t pin_direction_bank2_next;
	pgpio_word_t pin_data_bank2_next;

	////////////////////////////////////////////////////////////////////////
	// bus side signals

	logic        wr;
	logic [14:0] reg_idx;
	logic        adr_ok;
	pgpio_hit_t  hit;
	pgpio_hit_t  wr_hit;
	pgpio_word_t wdata;
	logic [1:0]  lanes;
	pgpio_word_t rd_word;

	pgpio_word_t data_bank1_view;
	logic [13:0] data_bank2_view;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// merge write data into a register by byte lane
	function automatic pgpio_word_t pgpio_lane_merge(
		input pgpio_word_t old_v,
		input pgpio_word_t new_v,
		input logic [1:0]  sel
	);
		pgpio_word_t r;
		r = old_v;
		if (sel[0]) begin
			r[7:0] = new_v[7:0];
		end
		if (sel[1]) begin
			r[15:8] = new_v[15:8];
		end
		return r;
	endfunction : pgpio_lane_merge

	// one-hot register select from word index
	function automatic pgpio_hit_t pgpio_decode(
		input logic [14:0] idx,
		input logic        ok
	);
		pgpio_hit_t h;
		h    = '0;
		h[0] = ok && (idx == `PGPIO_IDX_EN1);
		h[1] = ok && (idx == `PGPIO_IDX_DIR1);
		h[2] = ok && (idx == `PGPIO_IDX_DAT1);
		h[3] = ok && (idx == `PGPIO_IDX_EN2);
		h[4] = ok && (idx == `PGPIO_IDX_DIR2);
		h[5] = ok && (idx == `PGPIO_IDX_DAT2);
		return h;
	endfunction : pgpio_decode

	// read view of one pin: latch when output, pin level when input
	function automatic logic pgpio_pick(
		input logic dir,
		input logic lat,
		input logic pin
	);
		return dir ? lat : pin;
	endfunction : pgpio_pick

	////////////////////////////////////////////////////////////////////////
	// address decode

	assign reg_idx = wb_adr_i[`PGPIO_IDX_MSB:`PGPIO_IDX_LSB];
	assign adr_ok  = (wb_adr_i[31:`PGPIO_IDX_MSB+1] == 15'h0000) && (wb_adr_i[1:0] == 2'h0);
	assign hit     = pgpio_decode(reg_idx, adr_ok);
	assign wdata   = wb_dat_i[15:0];
	assign lanes   = wb_sel_i[1:0];
	assign wr_hit  = wr ? hit : '0;

	////////////////////////////////////////////////////////////////////////
	// next values, byte-lane merge on a write hit

	always_comb begin
		if (wr_hit[0]) begin
			pin_enable_bank1_next = pgpio_lane_merge(pin_enable_bank1_reg, wdata, lanes);
		end else begin
			pin_enable_bank1_next = pin_enable_bank1_reg;
		end
	end

	always_comb begin
		if (wr_hit[1]) begin
			pin_direction_bank1_next = pgpio_lane_merge(pin_direction_bank1_reg, wdata, lanes);
		end else begin
			pin_direction_bank1_next = pin_direction_bank1_reg;
		end
	end

	always_comb begin
		if (wr_hit[2]) begin
			pin_data_bank1_next = pgpio_lane_merge(pin_data_bank1_reg, wdata, lanes);
		end else begin
			pin_data_bank1_next = pin_data_bank1_reg;
		end
	end

	always_comb begin
		if (wr_hit[3]) begin
			pin_enable_bank2_next = pgpio_lane_merge(pin_enable_bank2_reg, wdata, lanes);
		end else begin
			pin_enable_bank2_next = pin_enable_bank2_reg;
		end
	end

	always_comb begin
		if (wr_hit[4]) begin
			pin_direction_bank2_next = pgpio_lane_merge(pin_direction_bank2_reg, wdata, lanes);
		end else begin
			pin_direction_bank2_next = pin_direction_bank2_reg;
		end
	end

	always_comb begin
		if (wr_hit[5]) begin
			pin_data_bank2_next = pgpio_lane_merge(pin_data_bank2_reg, wdata, lanes);
		end else begin
			pin_data_bank2_next = pin_data_bank2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 1 enable

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_enable_bank1_reg <= `PGPIO_EN_RST;
		end else begin
			pin_enable_bank1_reg <= pin_enable_bank1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 1 direction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_direction_bank1_reg <= `PGPIO_DIR_RST;
		end else begin
			pin_direction_bank1_reg <= pin_direction_bank1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 1 data latch

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_data_bank1_reg <= gpio_b1_i;
		end else begin
			pin_data_bank1_reg <= pin_data_bank1_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 2 enable

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_enable_bank2_reg <= `PGPIO_EN_RST;
		end else begin
			pin_enable_bank2_reg <= pin_enable_bank2_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 2 direction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_direction_bank2_reg <= `PGPIO_DIR_RST;
		end else begin
			pin_direction_bank2_reg <= pin_direction_bank2_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank 2 data latch

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_data_bank2_reg <= {`PGPIO_RSV_RST, gpio_b2_i};
		end else begin
			pin_data_bank2_reg <= pin_data_bank2_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data read view per pin

	genvar b;
	generate
		for (b = 0; b < `PGPIO_B1_W; b++) begin : g_view1
			assign data_bank1_view[b] = pgpio_pick(pin_direction_bank1_reg[b], pin_data_bank1_reg[b], gpio_b1_i[b]);
		end
		for (b = 0; b < `PGPIO_B2_W; b++) begin : g_view2
			// bit n is pin 32 plus n
			assign data_bank2_view[b] = pgpio_pick(pin_direction_bank2_reg[b], pin_data_bank2_reg[b], gpio_b2_i[b]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		rd_word = `PGPIO_WORD_ZERO;
		unique case (1'b1)
			hit[0]: begin
				rd_word = pin_enable_bank1_reg;
			end
			hit[1]: begin
				rd_word = pin_direction_bank1_reg;
			end
			hit[2]: begin
				rd_word = data_bank1_view;
			end
			hit[3]: begin
				rd_word = pin_enable_bank2_reg;
			end
			hit[4]: begin
				rd_word = pin_direction_bank2_reg;
			end
			hit[5]: begin
				rd_word = {pin_data_bank2_reg[15:14], data_bank2_view};
			end
			default: begin
				rd_word = `PGPIO_WORD_ZERO;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// bus front end

	pgpio_wb_slave u_bus (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wb_cyc_i  (wb_cyc_i),
		.wb_stb_i  (wb_stb_i),
		.wb_we_i   (wb_we_i),
		.rd_word_i (rd_word),
		.wb_dat_o  (wb_dat_o),
		.wb_ack_o  (wb_ack_o),
		.wr_o      (wr)
	);

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	pgpio_pin_bank #(
		.W (`PGPIO_B1_W)
	) u_pins1 (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.en_i     (pin_enable_bank1_reg),
		.dir_i    (pin_direction_bank1_reg),
		.dat_i    (pin_data_bank1_reg),
		.pin_o    (gpio_b1_o),
		.pin_oe_o (gpio_b1_oe_o)
	);

	// bank 2 pins 32 to 45
	pgpio_pin_bank #(
		.W (`PGPIO_B2_W)
	) u_pins2 (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.en_i     (pin_enable_bank2_reg[13:0]),
		.dir_i    (pin_direction_bank2_reg[13:0]),
		.dat_i    (pin_data_bank2_reg[13:0]),
		.pin_o    (gpio_b2_o),
		.pin_oe_o (gpio_b2_oe_o)
	);

endmodule : pgpio_top

// ===== common/pgpio_defs.svh
// Purpose: offsets, field widths and reset values of the upper parallel gpio banks
// Assumes: register index times four is the wishbone byte address
// Notes:   definitions only
`ifndef PGPIO_DEFS_SVH
`define PGPIO_DEFS_SVH

`define PGPIO_IDX_EN1     15'h4403
`define PGPIO_IDX_DIR1    15'h4404
`define PGPIO_IDX_DAT1    15'h4405
`define PGPIO_IDX_EN2     15'h4406
`define PGPIO_IDX_DIR2    15'h4407
`define PGPIO_IDX_DAT2    15'h4408

`define PGPIO_IDX_LSB     2
`define PGPIO_IDX_MSB     16
`define PGPIO_B1_W        16
`define PGPIO_B2_W        14
`define PGPIO_EN_RST      16'h0000
`define PGPIO_DIR_RST     16'h0000
`define PGPIO_RSV_RST     2'h0
`define PGPIO_WORD_ZERO   16'h0000

`endif

// ===== common/pgpio_pkg.sv
// Purpose: types shared by the upper parallel gpio banks
// Assumes: nothing beyond the defs header
// Notes:   register select is one-hot, one bit per register
package pgpio_pkg;

	typedef logic [15:0] pgpio_word_t;

	typedef logic [5:0] pgpio_hit_t;

	typedef enum logic [1:0] {
		PGPIO_IDLE = 2'b01,
		PGPIO_ACK  = 2'b10
	} pgpio_bus_state_t;

endpackage : pgpio_pkg

// ===== src/pgpio_pin_bank.sv
// Purpose: registered pin drivers for one bank of gpio pins
// Assumes: en, dir and data come from the register file
// Notes:   output enable high while the pin is driven
`timescale 1ns/1ps
module pgpio_pin_bank #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] en_i,
	input  wire logic [W-1:0] dir_i,
	input  wire logic [W-1:0] dat_i,
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe_o
);

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_pin
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_oe_o[g] <= 1'b0;
				end else begin
					pin_oe_o[g] <= en_i[g] & dir_i[g];
				end
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_o[g] <= 1'b0;
				end else begin
					pin_o[g] <= dat_i[g];
				end
			end
		end
	endgenerate

endmodule : pgpio_pin_bank

// ===== src/pgpio_wb_slave.sv
// Purpose: classic wishbone slave front end, one wait state per access
// Assumes: master holds the request until it sees ack
// Notes:   write strobe is asserted in the ack cycle only
`timescale 1ns/1ps
module pgpio_wb_slave
	import pgpio_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire pgpio_word_t rd_word_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wr_o
);

	pgpio_bus_state_t state_reg;
	logic             req;

	assign req  = wb_cyc_i & wb_stb_i;
	assign wr_o = (state_reg == PGPIO_ACK) & req & wb_we_i;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= PGPIO_IDLE;
			wb_ack_o  <= 1'b0;
		end else begin
			unique case (state_reg)
				PGPIO_IDLE: begin
					state_reg <= req ? PGPIO_ACK : PGPIO_IDLE;
					wb_ack_o  <= req;
				end
				PGPIO_ACK: begin
					state_reg <= PGPIO_IDLE;
					wb_ack_o  <= 1'b0;
				end
				default: begin
					state_reg <= PGPIO_IDLE;
					wb_ack_o  <= 1'b0;
				end
			endcase
		end
	end

	// read data captured with the request, zero above bit 15
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (state_reg == PGPIO_IDLE && req) begin
			wb_dat_o <= {16'h0000, rd_word_i};
		end
	end

endmodule : pgpio_wb_slave

// ===== tb/pgpio_top_chk.sv
// Purpose: bus and pin checks on pgpio_top ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every pgpio_top instance
`timescale 1ns/1ps
`include "pgpio_defs.svh"
module pgpio_top_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] gpio_b1_i,
	input wire logic [15:0] gpio_b1_o,
	input wire logic [15:0] gpio_b1_oe_o,
	input wire logic [13:0] gpio_b2_i,
	input wire logic [13:0] gpio_b2_o,
	input wire logic [13:0] gpio_b2_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_req_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_oe_reset: assert property ($past(rst_i) |-> gpio_b1_oe_o == 16'h0000
		&& gpio_b2_oe_o == 14'h0000)
		else $error("pin driven after reset");
	chk_oe_write: assert property ($changed({gpio_b1_oe_o, gpio_b2_oe_o}) |-> $past(wb_ack_o && wb_we_i, 2))
		else $error("output enable moved without write");
	chk_bad_adr: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
		|=> wb_dat_o == 32'h00000000)
		else $error("misaligned read not zero");
	chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
		else $error("read data moved while idle");
	chk_b2_drive: assert property (wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3
		&& wb_adr_i == {15'h0000, `PGPIO_IDX_DAT2, 2'h0} |=> ##1 gpio_b2_o == $past(wb_dat_i[13:0], 2))
		else $error("bank2 drive value wrong");

	cover property (wb_ack_o && !wb_we_i);
	cover property (wb_ack_o && wb_we_i);
	cover property (gpio_b2_oe_o != 14'h0000);
endmodule : pgpio_top_chk

bind pgpio_top pgpio_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .gpio_b1_i(gpio_b1_i), .gpio_b1_o(gpio_b1_o), .gpio_b1_oe_o(gpio_b1_oe_o),
	.gpio_b2_i(gpio_b2_i), .gpio_b2_o(gpio_b2_o), .gpio_b2_oe_o(gpio_b2_oe_o));

// ===== tb/pgpio_tb_top.sv
// Purpose: self-checking bench for pgpio_top
// Assumes: one wait state wishbone slave
// Notes:   reads queue their expected word
`timescale 1ns/1ps
`include "pgpio_defs.svh"
module pgpio_tb_top;
	localparam logic [31:0] ADR [4] = '{{15'h0, `PGPIO_IDX_EN1, 2'h0}, {15'h0, `PGPIO_IDX_DIR1, 2'h0},
		{15'h0, `PGPIO_IDX_EN2, 2'h0}, {15'h0, `PGPIO_IDX_DIR2, 2'h0}};
	localparam logic [31:0] A_DAT1 = {15'h0, `PGPIO_IDX_DAT1, 2'h0};
	localparam logic [31:0] A_DAT2 = {15'h0, `PGPIO_IDX_DAT2, 2'h0};
	logic        clk_i = 1'b0;
	logic        rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r, d;
	logic [3:0]  wb_sel_i;
	logic [15:0] gpio_b1_i, gpio_b1_o, gpio_b1_oe_o;
	logic [13:0] gpio_b2_i, gpio_b2_o, gpio_b2_oe_o;
	logic [15:0] regs [4];
	logic [31:0] exp_q [$];
	int          failures = 0;
	int          cmp_count = 0;

	pgpio_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.gpio_b1_i(gpio_b1_i), .gpio_b1_o(gpio_b1_o), .gpio_b1_oe_o(gpio_b1_oe_o),
		.gpio_b2_i(gpio_b2_i), .gpio_b2_o(gpio_b2_o), .gpio_b2_oe_o(gpio_b2_oe_o));

	always #4 clk_i = ~clk_i;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize();
		if (failures == 0 && cmp_count > 0 && exp_q.size() == 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] v, input logic [1:0] s,
		input logic [31:0] e);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= {2'h0, s};
		wb_dat_i <= {16'h0000, v};
		if (!w)
			exp_q.push_back(e);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 16) begin
			failures++;
			summarize();
		end
	endtask : wb

	task automatic pins(input logic [15:0] o1, input logic [15:0] e1, input logic [13:0] o2, input logic [13:0] e2);
		repeat (2) @(posedge clk_i);
		#1;
		check({gpio_b1_o, gpio_b1_oe_o}, {o1, e1});
		check({gpio_b2_o, gpio_b2_oe_o}, {o2, e2});
	endtask : pins

	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			check(wb_dat_o, exp_q.pop_front());

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 71'h0};
		void'($urandom(32'h39B39F1A));
		r = $urandom;
		gpio_b1_i = r[15:0];
		gpio_b2_i = r[29:16];
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++)
			wb(1'b0, ADR[i], 16'h0000, 2'h3, 32'h0);
		for (int i = 0; i < 4; i++)
			wb(1'b1, ADR[i], 16'hFFFF, 2'h3, 32'h0);
		gpio_b1_i <= ~r[15:0];
		pins(r[15:0], 16'hFFFF, r[29:16], 14'h3FFF);
		repeat (4) begin
			r = $urandom;
			d = $urandom;
			gpio_b1_i <= r[15:0];
			gpio_b2_i <= r[29:16];
			for (int i = 0; i < 4; i++) begin
				regs[i] = 16'($urandom);
				wb(1'b1, ADR[i], regs[i], 2'h3, 32'h0);
				wb(1'b0, ADR[i], 16'h0000, 2'h3, {16'h0, regs[i]});
			end
			wb(1'b1, A_DAT1, d[15:0], 2'h3, 32'h0);
			wb(1'b1, A_DAT2, d[31:16], 2'h3, 32'h0);
			pins(d[15:0], regs[0] & regs[1], d[29:16], regs[2][13:0] & regs[3][13:0]);
			wb(1'b0, A_DAT1, 16'h0, 2'h3, {16'h0, d[15:0] & regs[1] | r[15:0] & ~regs[1]});
			wb(1'b0, A_DAT2, 16'h0, 2'h3, {16'h0, d[31:30], d[29:16] & regs[3][13:0] | r[29:16] & ~regs[3][13:0]});
		end
		wb(1'b1, ADR[2], 16'hFFFF, 2'h1, 32'h0);
		regs[2][7:0] = 8'hFF;
		wb(1'b1, 32'h00011024, 16'h0000, 2'h3, 32'h0);
		wb(1'b0, ADR[2], 16'h0000, 2'h3, {16'h0, regs[2]});
		wb(1'b0, ADR[2] | 32'h1, 16'h0000, 2'h3, 32'h0);
		r = $urandom;
		gpio_b1_i <= r[15:0];
		gpio_b2_i <= r[29:16];
		rst_i     <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		pins(r[15:0], 16'h0000, r[29:16], 14'h0000);
		wb(1'b0, ADR[2], 16'h0000, 2'h3, 32'h0);
		repeat (3) @(posedge clk_i);
		summarize();
	end
endmodule : pgpio_tb_top
